// ===== hw/tlviu_ctrl.sv
`timescale 1ns/1ps
module tlviu_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // peripheral event pulses, one per order slot
  input wire logic [14:0] src_event,
  // extra multi-flag lines: serial rx/tx, timer2 hi/lo, sync serial 4, timer3 hi/lo
  input wire logic serial_rx_flag,
  input wire logic serial_tx_flag,
  input wire logic timer_two_high_overflow,
  input wire logic timer_two_low_overflow,
  input wire logic sync_serial_done_flag,
  input wire logic sync_serial_write_collision,
  input wire logic sync_serial_mode_fault,
  input wire logic sync_serial_rx_overrun,
  input wire logic timer_three_high_overflow,
  input wire logic timer_three_low_overflow,
  // flag clear pulses from peripherals or software elsewhere
  input wire logic [14:0] src_clear,
  // core side
  input wire logic insn_boundary,
  input wire logic return_from_interrupt,
  input wire logic call_ack,
  output tlviu_pkg::tlviu_call_s call_req
);
  import tlviu_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] basic_enable_reg_ff;
  logic [7:0] basic_priority_reg_ff;
  logic [7:0] extended_enable_reg_ff;
  logic [7:0] extended_priority_reg_ff;
  logic [14:0] pending_ff;
  logic [1:0] in_service_ff; // bit0 low, bit1 high
  logic ret_hold_ff;
  logic [7:0] rdata_ff;
  tlviu_call_s call_ff;
  logic global_irq_enable;
  logic [14:0] enable_vec;
  logic [14:0] prio_vec;
  logic [14:0] multi_any;
  logic [14:0] req_vec;
  logic [14:0] req_hi;
  logic [14:0] req_lo;
  logic pick_valid;
  logic pick_high;
  logic [3:0] pick_idx;

  assign global_irq_enable = basic_enable_reg_ff[TLVIU_GLOBAL_BIT];
  // slots 0..6 map to basic bits, 7..14 to extended bits 0..7 minus reserved
  assign enable_vec = {extended_enable_reg_ff[7], 1'b0, extended_enable_reg_ff[5:0],
                       basic_enable_reg_ff[6:0]};
  assign prio_vec = {extended_priority_reg_ff[7], 1'b0, extended_priority_reg_ff[5:0],
                     basic_priority_reg_ff[6:0]};
  // multi-flag sources request while any of their flags stands
  assign multi_any = {timer_three_high_overflow | timer_three_low_overflow, 7'h00,
                      sync_serial_done_flag | sync_serial_write_collision |
                      sync_serial_mode_fault | sync_serial_rx_overrun,
                      timer_two_high_overflow | timer_two_low_overflow,
                      serial_rx_flag | serial_tx_flag, 4'h0};

  // ****************************************
  // pending flags
  // ****************************************
  // set wins over clear so an event in the clear cycle is kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_ff <= 15'h0000;
    end else begin
      logic [14:0] clr;
      logic [14:0] set;
      clr = src_clear;
      if (call_ff.valid && call_ack) begin
        clr = clr | (TLVIU_AUTO_CLEAR & (15'h0001 << call_ff.order));
      end
      set = src_event;
      if (reg_wr && reg_addr == TLVIU_ADDR_PENDING_LO) begin
        set = set | {7'h00, reg_wdata};
        clr = clr | {7'h00, ~reg_wdata};
      end else if (reg_wr && reg_addr == TLVIU_ADDR_PENDING_HI) begin
        set = set | {reg_wdata[6:0], 8'h00};
        clr = clr | {~reg_wdata[6:0], 8'h00};
      end
      set[TLVIU_SRC_RESERVED] = 1'b0;
      pending_ff <= (pending_ff & ~clr) | set;
    end
  end

  // ****************************************
  // enable and priority registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      basic_enable_reg_ff <= TLVIU_RESET_REG;
      basic_priority_reg_ff <= TLVIU_RESET_REG;
      extended_enable_reg_ff <= TLVIU_RESET_REG;
      extended_priority_reg_ff <= TLVIU_RESET_REG;
    end else if (reg_wr) begin
      if (reg_addr == TLVIU_ADDR_BASIC_ENABLE) begin
        basic_enable_reg_ff <= reg_wdata;
      end else if (reg_addr == TLVIU_ADDR_BASIC_PRIORITY) begin
        basic_priority_reg_ff <= {1'b0, reg_wdata[6:0]};
      end else if (reg_addr == TLVIU_ADDR_EXT_ENABLE) begin
        extended_enable_reg_ff <= reg_wdata;
      end else if (reg_addr == TLVIU_ADDR_EXT_PRIORITY) begin
        extended_priority_reg_ff <= reg_wdata;
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == TLVIU_ADDR_BASIC_ENABLE) begin
        rdata_ff <= basic_enable_reg_ff;
      end else if (reg_addr == TLVIU_ADDR_BASIC_PRIORITY) begin
        rdata_ff <= basic_priority_reg_ff | TLVIU_BASIC_PRIO_FIXED;
      end else if (reg_addr == TLVIU_ADDR_EXT_ENABLE) begin
        rdata_ff <= extended_enable_reg_ff;
      end else if (reg_addr == TLVIU_ADDR_EXT_PRIORITY) begin
        rdata_ff <= extended_priority_reg_ff;
      end else if (reg_addr == TLVIU_ADDR_PENDING_LO) begin
        rdata_ff <= pending_ff[7:0];
      end else if (reg_addr == TLVIU_ADDR_PENDING_HI) begin
        rdata_ff <= {1'b0, pending_ff[14:8]};
      end else if (reg_addr == TLVIU_ADDR_STATUS) begin
        rdata_ff <= {5'h00, ret_hold_ff, in_service_ff};
      end else begin
        rdata_ff <= 8'h00;
      end
    end else begin
      rdata_ff <= 8'h00;
    end
  end
  assign reg_rdata = rdata_ff;

  // ****************************************
  // request and arbitration
  // ****************************************
  // level enables: a held flag requests as soon as enables turn on
  assign req_vec = (pending_ff | multi_any) & enable_vec & {15{global_irq_enable}};
  assign req_hi = req_vec & prio_vec;
  assign req_lo = req_vec & ~prio_vec;

  // decoded every cycle; lowest order wins within a level
  always_comb begin
    pick_valid = 1'b0;
    pick_high = 1'b0;
    pick_idx = 4'h0;
    if (!in_service_ff[1] && req_hi != 15'h0000) begin
      pick_valid = 1'b1;
      pick_high = 1'b1;
      for (int i = TLVIU_NUM_SLOTS - 1; i >= 0; i--) begin
        if (req_hi[i]) begin
          pick_idx = 4'(i);
        end
      end
    end else if (in_service_ff == 2'b00 && req_lo != 15'h0000) begin
      pick_valid = 1'b1;
      for (int i = TLVIU_NUM_SLOTS - 1; i >= 0; i--) begin
        if (req_lo[i]) begin
          pick_idx = 4'(i);
        end
      end
    end
  end

  // ****************************************
  // call to the core
  // ****************************************
  // taken only at an instruction boundary; after a return one more
  // instruction must finish first, which ret_hold enforces
  // a latched call stands even if its enable is cleared meanwhile
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      call_ff <= '0;
    end else if (call_ff.valid) begin
      if (call_ack) begin
        call_ff <= '0;
      end
    end else if (pick_valid && insn_boundary && !ret_hold_ff &&
                 !return_from_interrupt) begin
      call_ff.valid <= 1'b1;
      call_ff.order <= pick_idx;
      call_ff.vector <= TLVIU_VEC_FIRST + 16'(pick_idx) * TLVIU_VEC_STEP;
      call_ff.high <= pick_high;
    end
  end
  assign call_req = call_ff;

  // return blocks the next boundary so one instruction runs between
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ret_hold_ff <= 1'b0;
    end else if (return_from_interrupt) begin
      ret_hold_ff <= 1'b1;
    end else if (insn_boundary) begin
      ret_hold_ff <= 1'b0;
    end
  end

  // in-service levels; return ends the highest active one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_service_ff <= 2'b00;
    end else if (call_ff.valid && call_ack) begin
      if (call_ff.high) begin
        in_service_ff[1] <= 1'b1;
      end else begin
        in_service_ff[0] <= 1'b1;
      end
    end else if (return_from_interrupt) begin
      if (in_service_ff[1]) begin
        in_service_ff[1] <= 1'b0;
      end else begin
        in_service_ff[0] <= 1'b0;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_return_seen;
    return_from_interrupt;
  endsequence

  sequence s_call_raised;
    call_ff.valid && !call_ack;
  endsequence

  sequence s_call_taken;
    call_ff.valid && call_ack;
  endsequence

  sequence s_high_taken;
    call_ff.valid && call_ack && call_ff.high;
  endsequence

  a_no_call_global_off: assert property (@(posedge clk) disable iff (rst)
    !global_irq_enable && !call_ff.valid |=> !call_ff.valid)
    else $error("call raised with global enable off");

  a_reserved_never: assert property (@(posedge clk) disable iff (rst)
    call_ff.valid |-> call_ff.order != 4'(TLVIU_SRC_RESERVED))
    else $error("reserved slot vectored");

  a_vector_formula: assert property (@(posedge clk) disable iff (rst)
    call_ff.valid |-> call_ff.vector == 16'h0003 + 16'(call_ff.order) * 16'h0008)
    else $error("vector address wrong");

  a_high_not_preempt: assert property (@(posedge clk) disable iff (rst)
    in_service_ff[1] |-> !pick_valid)
    else $error("high routine preempted");

  a_high_first: assert property (@(posedge clk) disable iff (rst)
    (req_hi != 15'h0000) && !in_service_ff[1] |-> pick_high)
    else $error("low chosen over high");

  a_ret_one_insn: assert property (@(posedge clk) disable iff (rst)
    s_return_seen |=> !call_ff.valid)
    else $error("call directly after return");

  a_auto_clear: assert property (@(posedge clk) disable iff (rst)
    call_ff.valid && call_ack && call_ff.order == 4'h0 && !src_event[0] && !reg_wr
    |=> !pending_ff[0])
    else $error("pin flag not cleared");

  a_sticky_flag: assert property (@(posedge clk) disable iff (rst)
    call_ff.valid && call_ack && call_ff.order == 4'h4 && !src_clear[4] && !reg_wr
    && pending_ff[4] |=> pending_ff[4])
    else $error("serial flag cleared by hardware");

  a_prio_top_one: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == TLVIU_ADDR_BASIC_PRIORITY |=> reg_rdata[7])
    else $error("priority top bit not one");

  a_event_sets: assert property (@(posedge clk) disable iff (rst)
    src_event[0] |=> pending_ff[0])
    else $error("event lost");

  // ****************************************
  // handshake and level assertions
  // ****************************************
  // a call leaves only at a free boundary and stands until the core takes it
  a_call_holds: assert property (@(posedge clk) disable iff (rst)
    s_call_raised |=> call_ff.valid && $stable(call_ff.vector))
    else $error("call dropped before acceptance");

  a_call_drops: assert property (@(posedge clk) disable iff (rst)
    s_call_taken |=> !call_ff.valid)
    else $error("call kept after acceptance");

  a_boundary_only: assert property (@(posedge clk) disable iff (rst)
    !call_ff.valid && !insn_boundary |=> !call_ff.valid)
    else $error("call raised inside an instruction");

  a_decode_one_cycle: assert property (@(posedge clk) disable iff (rst)
    pick_valid && insn_boundary && !ret_hold_ff && !return_from_interrupt && !call_ff.valid
    |=> call_ff.valid)
    else $error("eligible request not latched");

  a_hold_blocks_call: assert property (@(posedge clk) disable iff (rst)
    ret_hold_ff && !call_ff.valid |=> !call_ff.valid)
    else $error("call before the instruction after return");

  a_high_sets_level: assert property (@(posedge clk) disable iff (rst)
    s_high_taken |=> in_service_ff[1])
    else $error("high level not entered");

  a_high_level_keeps: assert property (@(posedge clk) disable iff (rst)
    in_service_ff[1] && !return_from_interrupt |=> in_service_ff[1])
    else $error("high level left without return");

  a_return_ends_high: assert property (@(posedge clk) disable iff (rst)
    return_from_interrupt && in_service_ff[1] && !call_ff.valid |=> !in_service_ff[1])
    else $error("return did not end high level");

  a_low_waits: assert property (@(posedge clk) disable iff (rst)
    in_service_ff != 2'b00 && !call_ff.valid |=> !call_ff.valid || call_ff.high)
    else $error("low call while a routine runs");

  // ****************************************
  // request and register assertions
  // ****************************************
  // requests follow flags and enables, whatever raised the flag
  a_global_blocks: assert property (@(posedge clk) disable iff (rst)
    !global_irq_enable |-> req_vec == 15'h0000)
    else $error("request with global enable off");

  a_any_flag: assert property (@(posedge clk) disable iff (rst)
    sync_serial_mode_fault && enable_vec[6] && global_irq_enable |-> req_vec[6])
    else $error("sync serial flag ignored");

  a_timer_three_flag: assert property (@(posedge clk) disable iff (rst)
    timer_three_low_overflow && enable_vec[14] && global_irq_enable |-> req_vec[14])
    else $error("timer three flag ignored");

  a_held_flag: assert property (@(posedge clk) disable iff (rst)
    pending_ff[3] && enable_vec[3] && global_irq_enable |-> req_vec[3])
    else $error("held flag not requesting");

  a_tie_order: assert property (@(posedge clk) disable iff (rst)
    pick_valid && !pick_high && req_lo[3] |-> pick_idx <= 4'h3)
    else $error("later slot won a tie");

  a_sw_set: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == TLVIU_ADDR_PENDING_LO && reg_wdata[0] |=> pending_ff[0])
    else $error("software set lost");

  a_clear_timer_one: assert property (@(posedge clk) disable iff (rst)
    call_ff.valid && call_ack && call_ff.order == 4'h3 && !src_event[3] && !reg_wr
    |=> !pending_ff[3])
    else $error("timer flag not cleared");

  a_vector_range: assert property (@(posedge clk) disable iff (rst)
    call_ff.valid |-> call_ff.vector <= 16'h0073)
    else $error("vector beyond last slot");

  a_reserved_no_pend: assert property (@(posedge clk) disable iff (rst)
    pending_ff[TLVIU_SRC_RESERVED] == 1'b0)
    else $error("reserved slot pending");

  a_prio_top_zero: assert property (@(posedge clk) disable iff (rst)
    basic_priority_reg_ff[7] == 1'b0)
    else $error("priority top bit stored");

endmodule

// ===== hw/tlviu_pkg.sv
// Summary of operation
// - fourteen sources, each low or high priority
// - pending flags set regardless of enables
// - enabled pending flag requests long call after instruction
// - return resumes program, ends current level service
// - global enable bit seven gates every source
// - clear then single-cycle instruction may still interrupt
// - flag still set after return re-enters after one instruction
// - software flag set behaves like hardware event
// - high preempts low, high never preempted
// - high level first, then fixed source order
// - priority bits reset to low
// - sampled every cycle, five cycle minimum response
// - worst case response eighteen cycles
// - equal or higher active routine blocks until done
// - vectors from 0x0003 spaced eight, 0x006b reserved
// - hardware clears only pin and timer zero/one flags
// - enable and priority bits share bit positions
// - multi-flag sources request when any flag set
// - basic priority top bit reads one, ignores writes
package tlviu_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] TLVIU_ADDR_BASIC_ENABLE = 8'ha8;
  localparam logic [7:0] TLVIU_ADDR_BASIC_PRIORITY = 8'hb8;
  localparam logic [7:0] TLVIU_ADDR_EXT_ENABLE = 8'he6;
  localparam logic [7:0] TLVIU_ADDR_EXT_PRIORITY = 8'hf6;
  localparam logic [7:0] TLVIU_ADDR_PENDING_LO = 8'hc0;
  localparam logic [7:0] TLVIU_ADDR_PENDING_HI = 8'hc1;
  localparam logic [7:0] TLVIU_ADDR_STATUS = 8'hc2;
  localparam logic [7:0] TLVIU_RESET_REG = 8'h00;
  localparam logic [7:0] TLVIU_BASIC_PRIO_FIXED = 8'h80;
  localparam int TLVIU_GLOBAL_BIT = 7;

  // ****************************************
  // sources and vectors
  // ****************************************
  localparam int TLVIU_NUM_SLOTS = 15;
  localparam int TLVIU_SRC_RESERVED = 13;
  localparam logic [15:0] TLVIU_VEC_FIRST = 16'h0003;
  localparam logic [15:0] TLVIU_VEC_STEP = 16'h0008;
  localparam logic [14:0] TLVIU_AUTO_CLEAR = 15'h000f;
  localparam int TLVIU_LONG_CALL_CYCLES = 4;

  // call handshake to the core
  typedef struct packed {
    logic valid;
    logic [3:0] order;
    logic [15:0] vector;
    logic high;
  } tlviu_call_s;

endpackage

// ===== verification/tlviu_core_model.sv
`timescale 1ns/1ps
module tlviu_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controller side
  input tlviu_pkg::tlviu_call_s call_req,
  output logic call_ack,
  output logic insn_boundary,
  // pacing chosen by the bench
  input wire logic [3:0] ack_delay
);
  import tlviu_pkg::*;
  logic [3:0] wait_ff;
  logic [2:0] busy_ff;

  // accept a call after a chosen stall, then spend the long call without boundaries
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      call_ack <= 1'b0;
      wait_ff <= 4'h0;
      busy_ff <= 3'h0;
    end else begin
      call_ack <= 1'b0;
      if (call_req.valid && !call_ack) begin
        if (wait_ff >= ack_delay) begin
          call_ack <= 1'b1;
          wait_ff <= 4'h0;
          busy_ff <= 3'(TLVIU_LONG_CALL_CYCLES);
        end else begin
          wait_ff <= wait_ff + 4'h1;
        end
      end else if (busy_ff != 3'h0) begin
        busy_ff <= busy_ff - 3'h1;
      end
    end
  end

  // one-cycle instructions between calls, so a clear is never shadowed
  assign insn_boundary = (busy_ff == 3'h0) && !call_ack;
endmodule

// ===== verification/two_level_vectored_interrupt_unit_test.sv
`timescale 1ns/1ps
module two_level_vectored_interrupt_unit_test;
  import tlviu_pkg::*;
  logic clk, rst, reg_wr, reg_rd, return_from_interrupt, call_ack, insn_boundary;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [14:0] src_event, src_clear;
  logic [9:0] mf;
  logic [3:0] ack_delay;
  tlviu_call_s call_req;
  int failures, tests_run, cycles;
  // slot order served by each multi-flag line
  int mf_slot [10] = '{4, 4, 5, 5, 6, 6, 6, 6, 14, 14};

  tlviu_ctrl DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
    .serial_rx_flag(mf[0]), .serial_tx_flag(mf[1]), .timer_two_high_overflow(mf[2]),
    .timer_two_low_overflow(mf[3]), .sync_serial_done_flag(mf[4]),
    .sync_serial_write_collision(mf[5]), .sync_serial_mode_fault(mf[6]),
    .sync_serial_rx_overrun(mf[7]), .timer_three_high_overflow(mf[8]),
    .timer_three_low_overflow(mf[9]), .src_clear(src_clear), .insn_boundary(insn_boundary),
    .return_from_interrupt(return_from_interrupt), .call_ack(call_ack), .call_req(call_req));
  tlviu_core_model core (.clk(clk), .rst(rst), .call_req(call_req), .call_ack(call_ack),
    .insn_boundary(insn_boundary), .ack_delay(ack_delay));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // shared helpers
  // ****************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // trailing edge keeps the strobe from being raised twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0;
    #1 check(16'(reg_rdata), 16'(exp));
  endtask
  task automatic pulse(input logic [14:0] ev, input logic [14:0] cl, input logic ret);
    src_event <= ev; src_clear <= cl; return_from_interrupt <= ret;
    @(posedge clk); src_event <= '0; src_clear <= '0; return_from_interrupt <= 1'b0;
    @(posedge clk);
  endtask
  // the vector must still stand at the edge where the core accepts it
  task automatic wait_call(input logic [15:0] exp);
    int n;
    n = 0;
    while (call_ack !== 1'b1 && n < 40) begin
      @(posedge clk); #1 n++;
    end
    check(16'(call_ack), 16'h1);
    check(16'(call_req.valid), 16'h1);
    check(call_req.vector, exp);
    check(16'(call_req.order), (exp - 16'h0003) >> 3);
    @(posedge clk);
  endtask
  task automatic no_call(input int n);
    repeat (n) begin
      @(posedge clk); #1 check(16'(call_req.valid), 16'h0);
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_regs();
    rd_chk(8'ha8, 8'h00);
    rd_chk(8'hb8, 8'h80);
    rd_chk(8'he6, 8'h00);
    rd_chk(8'hf6, 8'h00);
    wr(8'hb8, 8'h7f);
    rd_chk(8'hb8, 8'hff);
    wr(8'hb8, 8'h00);
    rd_chk(8'h55, 8'h00);
  endtask
  task automatic t_masking();
    pulse(15'h0001, '0, 1'b0);
    no_call(4);
    rd_chk(8'hc0, 8'h01);
    wr(8'ha8, 8'h01);
    no_call(4);
    wr(8'ha8, 8'h81);
    wait_call(16'h0003);
    rd_chk(8'hc0, 8'h00);
    pulse('0, '0, 1'b1);
    wr(8'ha8, 8'hff);
    wr(8'he6, 8'hbf);
  endtask
  // every slot set by software in turn; slot 13 has no vector
  task automatic t_vectors();
    for (int k = 0; k < 15; k++) begin
      if (k < 8) wr(8'hc0, 8'(1 << k));
      else wr(8'hc1, 8'(1 << (k - 8)));
      if (k == 13) begin
        no_call(6);
      end else begin
        wait_call(16'h0003 + 16'(k * 8));
        rd_chk(k < 8 ? 8'hc0 : 8'hc1, k < 4 ? 8'h00 : 8'(1 << (k % 8)));
        pulse('0, 15'(1 << k), 1'b1);
      end
    end
  endtask
  // slow core here, so the request must hold until accepted
  task automatic t_multi_flag();
    ack_delay <= 4'h3;
    for (int i = 0; i < 10; i++) begin
      mf <= 10'(1 << i);
      wait_call(16'h0003 + 16'(mf_slot[i] * 8));
      mf <= '0;
      pulse('0, '0, 1'b1);
    end
    ack_delay <= 4'h0;
  endtask
  task automatic t_reenter();
    mf <= 10'h002;
    wait_call(16'h0023);
    pulse('0, '0, 1'b1);
    wait_call(16'h0023);
    mf <= '0;
    pulse('0, '0, 1'b1);
  endtask
  task automatic t_arbitration();
    for (int p = 0; p < 2; p++) begin
      wr(8'hb8, p ? 8'h20 : 8'h00);
      wr(8'hc0, 8'h28);
      wait_call(p ? 16'h002b : 16'h001b);
      pulse('0, 15'(p * 32), 1'b1);
      wait_call(p ? 16'h001b : 16'h002b);
      pulse('0, 15'h0020, 1'b1);
    end
  endtask
  task automatic t_preempt();
    wr(8'hf6, 8'h80);
    wr(8'hb8, 8'h01);
    wr(8'hc0, 8'h08);
    wait_call(16'h001b);
    wr(8'hc1, 8'h40);
    wait_call(16'h0073);
    rd_chk(8'hc2, 8'h03);
    pulse(15'h0001, '0, 1'b0);
    no_call(8);
    pulse('0, 15'h4000, 1'b1);
    wait_call(16'h0003);
    pulse('0, '0, 1'b1);
    pulse('0, '0, 1'b1);
    no_call(3);
    rd_chk(8'hc2, 8'h00);
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
    src_event = '0; src_clear = '0; mf = '0; return_from_interrupt = 1'b0;
    ack_delay = '0; failures = 0; tests_run = 0; cycles = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_regs();
    t_masking();
    t_vectors();
    t_multi_flag();
    t_reenter();
    t_arbitration();
    t_preempt();
    end_sim();
  end
endmodule
